// ### inc/bil_pkg.sv
// Shared constants and types of the boot image loader.
`default_nettype none
package bil_pkg;
   // Clock rate and the internal delay after the reset pin is released.
   localparam int CLK_MHZ = 25;
   localparam int BOOT_DELAY_NS = 15000;
   localparam int BOOT_DELAY_CYC = (BOOT_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int DELAY_W = 10;
   // Image format.
   localparam logic [31:0] NO_CRC_WORD = 32'h0D15AB1E;
   localparam logic [31:0] CRC_POLY = 32'hEDB88320;
   localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
   // Security word and one-time-programmable memory layout.
   localparam int SEC_BOOT_BIT = 5;
   localparam int OTP_AW = 11;
   localparam logic [10:0] OTP_SEC_ADDR = 11'h7FF;
   localparam logic [10:0] OTP_IMAGE_ADDR = 11'h000;
   // RAM layout; the program lands at and starts from the lowest word.
   localparam int RAM_AW = 15;
   localparam logic [14:0] RAM_BASE = 15'h0000;
   // Byte buffer between the sources and the parser.
   localparam int FIFO_W = 8;
   localparam int FIFO_D = 4;

   typedef enum logic [3:0] {
      ST_HOLD, ST_DELAY, ST_SEC, ST_SEC_WAIT, ST_LEN, ST_PROG, ST_CHK,
      ST_DECIDE, ST_RUN, ST_ERR
   } bil_state_t;

   typedef struct packed {
      logic we;
      logic [14:0] addr;
      logic [31:0] data;
   } bil_ram_wr_t;

   typedef struct packed {
      logic core_reset;
      logic start;
      logic [14:0] entry;
      logic boot_err;
   } bil_core_ctl_t;
endpackage : bil_pkg
`default_nettype wire

// ### rtl/bil_loader.sv
// Boot sequencer, image parser and CRC checker with its byte FIFO.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Synchronous FIFO with valid and ready on both sides.
module bil_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic wr_valid,
   output logic wr_ready,
   output logic [WIDTH-1:0] rd_data,
   output logic rd_valid,
   input wire logic rd_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wp_reg;
   logic [AW-1:0] rp_reg;
   logic [AW:0] cnt_reg;
   logic push;
   logic pop;

   assign wr_ready = (cnt_reg != (AW+1)'(DEPTH));
   assign rd_valid = (cnt_reg != '0);
   assign rd_data = mem_reg[rp_reg];
   assign push = wr_valid && wr_ready;
   assign pop = rd_valid && rd_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wp_reg] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
         end
         if (pop) begin
            rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : bil_fifo

////////////////////////////////////////////////////////////////////////////////
module bil_loader (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic rst_pin_n,
   output logic gpio_pulldown_en,
   output bil_pkg::bil_core_ctl_t core_ctl,
   output bil_pkg::bil_ram_wr_t ram_wr,
   output logic otp_rd,
   output logic [10:0] otp_addr,
   input wire logic [31:0] otp_rdata,
   output logic flash_sel,
   input wire logic link_clk,
   input wire logic [3:0] link_nib,
   input wire logic link_valid,
   output logic link_ready
);
   ////////////////////////////////////////////////////////////////////////////
   // Reset pin synchroniser and boot sequencer.
   logic pin_meta_reg;
   logic pin_sync_reg;
   bil_pkg::bil_state_t state_reg;
   bil_pkg::bil_state_t state_next;
   logic [9:0] delay_reg;
   logic secure_reg;
   logic [31:0] word_reg;
   logic [31:0] word_next;
   logic [1:0] bidx_reg;
   logic [31:0] crc_reg;
   logic [31:0] crc_next;
   logic [31:0] left_reg;
   logic [31:0] chk_reg;
   logic [14:0] waddr_reg;
   logic byte_take;
   logic word_done;
   logic loading;
   logic otp_dv_reg;
   logic [7:0] fifo_out;
   logic fifo_out_valid;
   logic fifo_in_ready;
   logic [7:0] fifo_in;
   logic fifo_in_valid;

   always_ff @(posedge ref_clk) begin
      pin_meta_reg <= rst_pin_n;
      pin_sync_reg <= pin_meta_reg;
   end

   assign loading = (state_reg == bil_pkg::ST_LEN)
                    || (state_reg == bil_pkg::ST_PROG)
                    || (state_reg == bil_pkg::ST_CHK);
   assign byte_take = loading && fifo_out_valid;
   assign word_next = {fifo_out, word_reg[31:8]};
   assign word_done = byte_take && (bidx_reg == 2'h3);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         bil_pkg::ST_HOLD: begin
            if (pin_sync_reg) begin
               state_next = bil_pkg::ST_DELAY;
            end
         end
         bil_pkg::ST_DELAY: begin
            if (delay_reg == 10'(bil_pkg::BOOT_DELAY_CYC - 1)) begin
               state_next = bil_pkg::ST_SEC;
            end
         end
         bil_pkg::ST_SEC: state_next = bil_pkg::ST_SEC_WAIT;
         bil_pkg::ST_SEC_WAIT: begin
            if (otp_dv_reg) begin
               state_next = bil_pkg::ST_LEN;
            end
         end
         bil_pkg::ST_LEN: begin
            if (word_done) begin
               state_next = (word_next == '0) ? bil_pkg::ST_CHK
                                              : bil_pkg::ST_PROG;
            end
         end
         bil_pkg::ST_PROG: begin
            if (word_done && left_reg == 32'h00000001) begin
               state_next = bil_pkg::ST_CHK;
            end
         end
         bil_pkg::ST_CHK: begin
            if (word_done) begin
               state_next = bil_pkg::ST_DECIDE;
            end
         end
         bil_pkg::ST_DECIDE: begin
            if (chk_reg == bil_pkg::NO_CRC_WORD || ~crc_reg == chk_reg) begin
               state_next = bil_pkg::ST_RUN;
            end else begin
               state_next = bil_pkg::ST_ERR;
            end
         end
         bil_pkg::ST_RUN: state_next = bil_pkg::ST_RUN;
         bil_pkg::ST_ERR: state_next = bil_pkg::ST_ERR;
         default: state_next = bil_pkg::ST_HOLD;
      endcase
      // A low pin wins at once, so the held outputs follow it without lag.
      if (!pin_sync_reg) begin
         state_next = bil_pkg::ST_HOLD;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst || !pin_sync_reg) begin
         state_reg <= bil_pkg::ST_HOLD;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (state_reg == bil_pkg::ST_DELAY) begin
         delay_reg <= delay_reg + 10'h001;
      end else begin
         delay_reg <= '0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst || state_reg == bil_pkg::ST_HOLD) begin
         secure_reg <= 1'b0;
      end else if (state_reg == bil_pkg::ST_SEC_WAIT && otp_dv_reg) begin
         secure_reg <= otp_rdata[bil_pkg::SEC_BOOT_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Image parser, CRC and RAM writer.
   always_comb begin
      crc_next = crc_reg ^ {24'h000000, fifo_out};
      for (int i = 0; i < 8; i++) begin
         crc_next = crc_next[0] ? ((crc_next >> 1) ^ bil_pkg::CRC_POLY)
                                : (crc_next >> 1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!loading) begin
         bidx_reg <= 2'h0;
         word_reg <= '0;
      end else if (byte_take) begin
         bidx_reg <= bidx_reg + 2'h1;
         word_reg <= word_next;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (state_reg == bil_pkg::ST_SEC) begin
         crc_reg <= bil_pkg::CRC_INIT;
      end else if (byte_take && state_reg != bil_pkg::ST_CHK) begin
         crc_reg <= crc_next;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (state_reg == bil_pkg::ST_LEN && word_done) begin
         left_reg <= word_next;
      end else if (state_reg == bil_pkg::ST_PROG && word_done) begin
         left_reg <= left_reg - 32'h00000001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (state_reg == bil_pkg::ST_CHK && word_done) begin
         chk_reg <= word_next;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst || state_reg == bil_pkg::ST_SEC) begin
         waddr_reg <= bil_pkg::RAM_BASE;
         ram_wr <= '0;
      end else begin
         ram_wr.we <= (state_reg == bil_pkg::ST_PROG) && word_done;
         ram_wr.addr <= waddr_reg;
         ram_wr.data <= word_next;
         if (state_reg == bil_pkg::ST_PROG && word_done) begin
            waddr_reg <= waddr_reg + 15'h0001;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         core_ctl <= '{core_reset: 1'b1, start: 1'b0, entry: 15'h0000,
                       boot_err: 1'b0};
         gpio_pulldown_en <= 1'b1;
      end else begin
         core_ctl.core_reset <= (state_next != bil_pkg::ST_RUN);
         core_ctl.start <= (state_next == bil_pkg::ST_RUN);
         core_ctl.entry <= bil_pkg::RAM_BASE;
         core_ctl.boot_err <= (state_next == bil_pkg::ST_ERR);
         gpio_pulldown_en <= (state_next == bil_pkg::ST_HOLD);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // OTP reader: security word first, then image words unpacked LSB first.
   logic [31:0] ob_word_reg;
   logic [2:0] ob_cnt_reg;
   logic [10:0] fetch_addr_reg;
   logic fetch_go;
   logic otp_push;

   assign fetch_go = loading && secure_reg && ob_cnt_reg == 3'h0
                     && !otp_rd && !otp_dv_reg;
   assign otp_push = secure_reg && ob_cnt_reg != 3'h0 && fifo_in_ready;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         otp_rd <= 1'b0;
         otp_addr <= '0;
         otp_dv_reg <= 1'b0;
      end else begin
         otp_rd <= (state_reg == bil_pkg::ST_SEC) || fetch_go;
         otp_addr <= (state_reg == bil_pkg::ST_SEC) ? bil_pkg::OTP_SEC_ADDR
                                                    : fetch_addr_reg;
         otp_dv_reg <= otp_rd;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (state_reg == bil_pkg::ST_SEC || sys_rst) begin
         fetch_addr_reg <= bil_pkg::OTP_IMAGE_ADDR;
         ob_cnt_reg <= 3'h0;
         ob_word_reg <= '0;
      end else if (loading && otp_dv_reg) begin
         ob_word_reg <= otp_rdata;
         ob_cnt_reg <= 3'h4;
         fetch_addr_reg <= fetch_addr_reg + 11'h001;
      end else if (otp_push) begin
         ob_word_reg <= {8'h00, ob_word_reg[31:8]};
         ob_cnt_reg <= ob_cnt_reg - 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flash link: nibbles on link_clk, bytes handed over by toggle handshake.
   logic lrst_meta_reg;
   logic lrst_reg;
   logic sel_meta_reg;
   logic sel_sync_reg;
   logic hi_done_reg;
   logic [3:0] hi_nib_reg;
   logic [7:0] lbyte_reg;
   logic req_tgl_reg;
   logic ack_meta_reg;
   logic ack_sync_reg;
   logic lbusy_reg;
   logic lbusy_next;
   logic nib_take;
   logic req_meta_reg;
   logic req_s2_reg;
   logic req_s3_reg;
   logic ack_tgl_reg;
   logic pend_reg;
   logic flash_push;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         flash_sel <= 1'b0;
      end else begin
         flash_sel <= loading && !secure_reg;
      end
   end

   always_ff @(posedge link_clk) begin
      lrst_meta_reg <= sys_rst;
      lrst_reg <= lrst_meta_reg;
      sel_meta_reg <= flash_sel;
      sel_sync_reg <= sel_meta_reg;
      ack_meta_reg <= ack_tgl_reg;
      ack_sync_reg <= ack_meta_reg;
   end

   assign nib_take = link_valid && link_ready;

   always_comb begin
      lbusy_next = lbusy_reg;
      if (ack_sync_reg == req_tgl_reg) begin
         lbusy_next = 1'b0;
      end
      if (nib_take && hi_done_reg) begin
         lbusy_next = 1'b1;
      end
   end

   always_ff @(posedge link_clk) begin
      if (lrst_reg) begin
         hi_done_reg <= 1'b0;
         hi_nib_reg <= '0;
         lbyte_reg <= '0;
         req_tgl_reg <= 1'b0;
         lbusy_reg <= 1'b0;
         link_ready <= 1'b0;
      end else begin
         lbusy_reg <= lbusy_next;
         link_ready <= sel_sync_reg && !lbusy_next;
         if (nib_take) begin
            hi_done_reg <= !hi_done_reg;
            hi_nib_reg <= link_nib;
            if (hi_done_reg) begin
               lbyte_reg <= {hi_nib_reg, link_nib};
               req_tgl_reg <= !req_tgl_reg;
            end
         end
         // A frame cut by a deselect must not leave half a byte behind.
         if (!sel_sync_reg) begin
            hi_done_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      req_meta_reg <= req_tgl_reg;
      req_s2_reg <= req_meta_reg;
   end

   assign flash_push = pend_reg && fifo_in_ready && !secure_reg;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         req_s3_reg <= 1'b0;
         pend_reg <= 1'b0;
         ack_tgl_reg <= 1'b0;
      end else begin
         req_s3_reg <= req_s2_reg;
         if (req_s2_reg != req_s3_reg) begin
            pend_reg <= 1'b1;
         end else if (flash_push || (pend_reg && !flash_sel)) begin
            // A byte left over from a cut load is dropped but acknowledged.
            pend_reg <= 1'b0;
            ack_tgl_reg <= !ack_tgl_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Byte buffer feeding the parser from the selected source.
   assign fifo_in = secure_reg ? ob_word_reg[7:0] : lbyte_reg;
   assign fifo_in_valid = secure_reg ? (ob_cnt_reg != 3'h0) : pend_reg;

   bil_fifo #(
      .WIDTH(bil_pkg::FIFO_W),
      .DEPTH(bil_pkg::FIFO_D)
   ) u_fifo (
      .clk(ref_clk),
      .rst(sys_rst || state_reg == bil_pkg::ST_SEC),
      .wr_data(fifo_in),
      .wr_valid(fifo_in_valid),
      .wr_ready(fifo_in_ready),
      .rd_data(fifo_out),
      .rd_valid(fifo_out_valid),
      .rd_ready(loading)
   );
endmodule : bil_loader
`default_nettype wire

// ### testbench/bil_loader_monitor.sv
// Concurrent checks on the ports of the boot image loader.
`timescale 1ns/1ps
`default_nettype none
module bil_loader_monitor (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic rst_pin_n,
   input wire logic gpio_pulldown_en,
   input wire bil_pkg::bil_core_ctl_t core_ctl,
   input wire bil_pkg::bil_ram_wr_t ram_wr,
   input wire logic otp_rd,
   input wire logic [10:0] otp_addr,
   input wire logic flash_sel,
   input wire logic link_ready
);
   localparam int T_MIN = 375;
   localparam int T_MAX = 400;
   logic [10:0] hi_cnt;
   logic [14:0] wr_cnt;
   logic first_pend;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   // Helpers restart with the pin so that each boot is judged alone.
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !rst_pin_n) begin
         hi_cnt <= 11'h000;
         wr_cnt <= 15'h0000;
         first_pend <= 1'b0;
      end else begin
         if (hi_cnt != 11'h7FF) begin
            hi_cnt <= hi_cnt + 11'h001;
         end
         if (ram_wr.we) begin
            wr_cnt <= wr_cnt + 15'h0001;
         end
         if (otp_rd) begin
            first_pend <= otp_addr == bil_pkg::OTP_SEC_ADDR;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   property p_pulldown;
      !rst_pin_n [*4] |-> gpio_pulldown_en && core_ctl.core_reset;
   endproperty
   property p_no_early;
      rst_pin_n && hi_cnt < T_MIN |-> !otp_rd && !flash_sel;
   endproperty
   property p_boot_start;
      $rose(rst_pin_n) |->
         ##[T_MIN:T_MAX] otp_rd && otp_addr == bil_pkg::OTP_SEC_ADDR;
   endproperty
   property p_otp_word0;
      otp_rd && first_pend |->
         otp_addr == bil_pkg::OTP_IMAGE_ADDR && !flash_sel;
   endproperty
   property p_ram_addr;
      ram_wr.we && rst_pin_n |-> ram_wr.addr == bil_pkg::RAM_BASE + wr_cnt;
   endproperty
   property p_we_pulse;
      ram_wr.we |=> !ram_wr.we [*3];
   endproperty
   property p_start;
      core_ctl.start |-> !core_ctl.core_reset && !core_ctl.boot_err &&
         core_ctl.entry == bil_pkg::RAM_BASE;
   endproperty
   property p_err;
      core_ctl.boot_err && rst_pin_n |=>
         core_ctl.boot_err && core_ctl.core_reset && !core_ctl.start;
   endproperty
   property p_link_off;
      !flash_sel [*8] |-> !link_ready;
   endproperty
   a_pulldown: assert property (p_pulldown) else $error("pin hold");
   a_no_early: assert property (p_no_early) else $error("early");
   a_boot_start: assert property (p_boot_start)
      else $error("late");
   a_otp_word0: assert property (p_otp_word0) else $error("otp");
   a_ram_addr: assert property (p_ram_addr) else $error("addr");
   a_we_pulse: assert property (p_we_pulse) else $error("we");
   a_start: assert property (p_start) else $error("start");
   a_err: assert property (p_err) else $error("error flag");
   a_link_off: assert property (p_link_off) else $error("link");
   c_run: cover property (core_ctl.start);
   c_err: cover property (core_ctl.boot_err);
   c_otp: cover property (otp_rd && first_pend);
endmodule : bil_loader_monitor

bind bil_loader bil_loader_monitor i_bil_loader_monitor (.*);
`default_nettype wire

// ### testbench/bil_flash_model.sv
// Behavioural model of the boot flash on the nibble link.
`timescale 1ns/1ps
`default_nettype none
module bil_flash_model (
   input wire logic sys_rst,
   input wire logic flash_sel,
   input wire logic link_ready,
   output logic link_clk,
   output logic [3:0] link_nib,
   output logic link_valid
);
   logic [7:0] q [$];
   logic [7:0] b;
   logic took = 1'b0;
   int gap = 0;
   // The link clock only runs during reset and while the link is in use.
   initial begin
      link_clk = 1'b0;
      #7;
      forever begin
         #16;
         link_clk = (sys_rst || flash_sel || link_ready || link_valid) ?
            ~link_clk : 1'b0;
      end
   end
   always @(posedge link_clk) begin
      took <= link_valid && link_ready;
   end
   task automatic send(input logic [3:0] n);
      link_nib = n;
      link_valid = 1'b1;
      do begin
         @(posedge link_clk);
         #1;
      end while (!took && flash_sel);
   endtask : send
   // Each byte goes high nibble first; a released line shows the inverse.
   initial begin
      link_valid = 1'b0;
      link_nib = 4'h5;
      forever begin
         wait (q.size() != 0 && flash_sel === 1'b1);
         @(posedge link_clk);
         #1;
         repeat (gap) begin
            @(posedge link_clk);
            #1;
         end
         // The byte is taken only now, so a cut load never resends it.
         if (q.size() != 0 && flash_sel === 1'b1) begin
            b = q.pop_front();
            send(b[7:4]);
            if (flash_sel) begin
               send(b[3:0]);
            end
            link_valid = 1'b0;
            link_nib = ~link_nib;
         end
      end
   end
endmodule : bil_flash_model
`default_nettype wire

// ### testbench/test_boot_image_loader.sv
// Self-checking bench of the boot image loader.
`timescale 1ns/1ps
`default_nettype none
module test_boot_image_loader;
   logic ref_clk, sys_rst, rst_pin_n, gpio_pulldown_en, otp_rd, flash_sel;
   logic link_clk, link_valid, link_ready, saw_flash;
   logic [10:0] otp_addr;
   logic [31:0] otp_rdata;
   logic [3:0] link_nib;
   bil_pkg::bil_core_ctl_t core_ctl;
   bil_pkg::bil_ram_wr_t ram_wr;
   logic [31:0] otp_mem [0:2047];
   logic [31:0] exp_w [$];
   int fails = 0;
   int n_compared = 0;
   int seed = 37;
   int widx = 0;
   int r;
   bil_loader i_bil_loader (.*);
   bil_flash_model i_bil_flash_model (.*);
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   function automatic logic [31:0] crc8(input logic [31:0] c,
                                        input logic [7:0] d);
      c = c ^ {24'h000000, d};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? (c >> 1) ^ bil_pkg::CRC_POLY : c >> 1;
      end
      return c;
   endfunction : crc8
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict
   // The memory answers on the falling edge and holds until the next read.
   always @(negedge ref_clk) begin
      if (otp_rd === 1'b1) begin
         otp_rdata <= otp_mem[otp_addr];
      end
   end
   always @(negedge ref_clk) begin
      if (flash_sel === 1'b1) begin
         saw_flash = 1'b1;
      end
      if (ram_wr.we === 1'b1) begin
         check("ram addr", {17'h00000, ram_wr.addr}, 32'(widx));
         check("ram word", ram_wr.data, exp_w[widx]);
         widx++;
      end
   end
   task automatic boot(input logic sec, input int nw, input int mode,
                       input int gap, input int abort);
      logic [31:0] w [$];
      logic [31:0] crc;
      int k;
      // Hold the pin first so that a load in flight is cut before the
      // flash queue and the memory are refilled.
      @(negedge ref_clk);
      rst_pin_n = 1'b0;
      repeat (5) @(negedge ref_clk);
      crc = bil_pkg::CRC_INIT;
      w.push_back(32'(nw));
      for (k = 0; k < nw; k++) begin
         w.push_back($random(seed));
      end
      exp_w = w[1:$];
      for (k = 0; k < 4 * w.size(); k++) begin
         crc = crc8(crc, w[k / 4][8 * (k % 4) +: 8]);
      end
      crc = ~crc;
      w.push_back(mode == 0 ? crc : mode == 1 ? ~crc : bil_pkg::NO_CRC_WORD);
      otp_mem[bil_pkg::OTP_SEC_ADDR] = $random(seed);
      otp_mem[bil_pkg::OTP_SEC_ADDR][bil_pkg::SEC_BOOT_BIT] = sec;
      i_bil_flash_model.q.delete();
      i_bil_flash_model.gap = gap;
      for (k = 0; k < 4 * w.size(); k++) begin
         if (sec) begin
            otp_mem[bil_pkg::OTP_IMAGE_ADDR + k / 4] = w[k / 4];
         end else begin
            i_bil_flash_model.q.push_back(w[k / 4][8 * (k % 4) +: 8]);
         end
      end
      check("pulldown", gpio_pulldown_en, 1'b1);
      check("held", core_ctl.core_reset, 1'b1);
      widx = 0;
      saw_flash = 1'b0;
      rst_pin_n = 1'b1;
      k = 0;
      while (core_ctl.start !== 1'b1 && core_ctl.boot_err !== 1'b1 &&
             k < 4000 && (abort == 0 || k < abort)) begin
         @(negedge ref_clk);
         k++;
      end
      if (abort == 0) begin
         check("in time", k < 4000, 1'b1);
         check("words", widx, nw);
         check("start", core_ctl.start, mode != 1);
         check("error", core_ctl.boot_err, mode == 1);
         check("entry", core_ctl.entry, bil_pkg::RAM_BASE);
         check("flash", saw_flash, !sec);
      end
      $display("test done: sec %0d words %0d mode %0d", sec, nw, mode);
   endtask : boot
   initial begin
      sys_rst = 1'b1;
      rst_pin_n = 1'b0;
      otp_rdata = 32'h00000000;
      saw_flash = 1'b0;
      repeat (3) @(negedge ref_clk);
      sys_rst = 1'b0;
      #1ms;
      boot(1'b0, 3, 0, 0, 0);
      boot(1'b0, 1, 1, 2, 0);
      boot(1'b0, 2, 2, 0, 0);
      boot(1'b0, 0, 0, 3, 0);
      boot(1'b1, 4, 0, 0, 0);
      boot(1'b1, 2, 1, 0, 0);
      boot(1'b0, 8, 0, 0, 600);
      for (r = 0; r < 4; r++) begin
         boot($random(seed) & 1, ($random(seed) & 3) + 1, r % 3, r, 0);
      end
      give_verdict();
   end
   initial begin
      #4ms;
      fails++;
      $display("watchdog expired");
      give_verdict();
   end
endmodule : test_boot_image_loader
`default_nettype wire
